// ---- pkg/dds_consts.svh ----
// Purpose: shared constants of the dual converter serial-input block
// Assumes: included by the package and by every design file
// Notes: field positions, register offsets and reset values live here
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH

// ****************************************
// word layout
// ****************************************
`define DDS_WORD_W 16
`define DDS_CODE_W 10
`define DDS_LAST_BIT 4'hF
`define DDS_MODE_LOAD 2'h0
`define DDS_MODE_UPD 2'h1
`define DDS_MODE_ALL 2'h2
`define DDS_MODE_PD 2'h3
`define DDS_SEL_A 2'h0
`define DDS_SEL_B 2'h1

// ****************************************
// register map
// ****************************************
`define DDS_AW 8
`define DDS_ADDR_CTRL 8'h00
`define DDS_ADDR_STATUS 8'h04
`define DDS_ADDR_CODE_A 8'h08
`define DDS_ADDR_CODE_B 8'h0C
`define DDS_ADDR_LAST 8'h10
`define DDS_ADDR_COUNT 8'h14
`define DDS_CTRL_EN_BIT 0
`define DDS_CTRL_CLR_BIT 1
`define DDS_CTRL_EN_RST 1'h1
`define DDS_CNT_W 16

`endif

// ---- pkg/dds_pkg.sv ----
// Purpose: types of the dual converter serial-input block
// Assumes: dds_consts.svh on the include path
// Notes: none
`default_nettype none
`include "dds_consts.svh"
package dds_pkg;

  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] mode;
    logic [`DDS_CODE_W-1:0] code;
    logic [1:0] spare;
  } dds_word_t;

  typedef struct packed {
    logic valid;
    logic abort;
    dds_word_t word;
  } dds_rx_evt_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_SHIFT = 2'h1,
    RX_DONE = 2'h2
  } dds_rx_state_t;

  function automatic logic dds_sel_hit(input logic [1:0] sel, input logic [1:0] ch);
    return sel == ch;
  endfunction : dds_sel_hit

endpackage : dds_pkg
`default_nettype wire

// ---- rtl/dds_frame_rx.sv ----
// Purpose: serial frame receiver, pins sampled on pclk
// Assumes: serial clock well below pclk/4
// Notes: one-cycle valid or abort event per frame that starts while enable is high
`default_nettype none
`include "dds_consts.svh"
module dds_frame_rx import dds_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  // control and result
  input wire logic enable,
  output var dds_rx_evt_t evt,
  output logic busy
);

  logic sclk_s1, sclk_s2, sclk_s3;
  logic sync_s1, sync_s2;
  logic din_s1, din_s2;
  logic sclk_fall;
  logic [3:0] bit_cnt;
  logic [`DDS_WORD_W-1:0] shift_reg;
  dds_rx_state_t state;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1 <= 1'h1;
      sclk_s2 <= 1'h1;
      sclk_s3 <= 1'h1;
      sync_s1 <= 1'h1;
      sync_s2 <= 1'h1;
      din_s1 <= 1'h0;
      din_s2 <= 1'h0;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sync_s1 <= sync_n;
      sync_s2 <= sync_s1;
      din_s1 <= din;
      din_s2 <= din_s1;
    end
  end

  assign sclk_fall = sclk_s3 & ~sclk_s2;

  // ****************************************
  // frame state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RX_IDLE;
    end else begin
      case (state)
        RX_IDLE: if (!sync_s2 && enable) state <= RX_SHIFT;
        RX_SHIFT: begin
          if (sync_s2) state <= RX_IDLE;
          else if (sclk_fall && bit_cnt == `DDS_LAST_BIT) state <= RX_DONE;
        end
        RX_DONE: if (sync_s2) state <= RX_IDLE;
        default: state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= '0;
      shift_reg <= '0;
    end else if (sync_s2 || state != RX_SHIFT) begin
      bit_cnt <= '0;
      shift_reg <= '0;
    end else if (sclk_fall) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift_reg <= {shift_reg[`DDS_WORD_W-2:0], din_s2};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= '0;
      busy <= 1'h0;
    end else begin
      evt.valid <= state == RX_SHIFT && !sync_s2 && sclk_fall
                   && bit_cnt == `DDS_LAST_BIT;
      evt.abort <= state == RX_SHIFT && sync_s2;
      evt.word <= {shift_reg[`DDS_WORD_W-2:0], din_s2};
      busy <= state != RX_IDLE;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  frame_len_a: assert property (
    evt.valid |-> $past(bit_cnt) == `DDS_LAST_BIT && $past(sclk_fall))
    else $error("word taken without sixteen falls");
  sync_gate_a: assert property (sync_s2 |=> bit_cnt == '0)
    else $error("bits counted with frame sync high");
  abort_cause_a: assert property (
    evt.abort |-> $past(sync_s2) && $past(state) == RX_SHIFT)
    else $error("abort without early frame sync rise");

endmodule : dds_frame_rx
`default_nettype wire

// ---- rtl/dds_top.sv ----
// Purpose: dual 10-bit converter serial input and update control
// Assumes: APB master; serial pins asynchronous to pclk
// Notes: outputs carry the converter codes and power-down state
//
// The APB register port and the register addresses are this design's own decisions.
`default_nettype none
`include "dds_consts.svh"
module dds_top import dds_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DDS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  // converter side
  output logic [`DDS_CODE_W-1:0] code_a,
  output logic [`DDS_CODE_W-1:0] code_b,
  output logic pd_active,
  output logic [1:0] pd_term
);

  dds_rx_evt_t evt;
  dds_word_t wd;
  logic rx_busy;
  logic ctrl_en_reg;
  logic [`DDS_CODE_W-1:0] in_a_reg;
  logic [`DDS_CODE_W-1:0] in_b_reg;
  logic [`DDS_CODE_W-1:0] code_a_reg;
  logic [`DDS_CODE_W-1:0] code_b_reg;
  logic pd_reg;
  logic [1:0] term_reg;
  logic [`DDS_WORD_W-1:0] last_reg;
  logic [`DDS_CNT_W-1:0] ok_cnt_reg;
  logic [`DDS_CNT_W-1:0] abort_cnt_reg;
  logic seen_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic apb_access;
  logic apb_wr;
  logic cnt_clr;
  logic hit;
  logic is_load;
  logic is_upd;
  logic is_all;
  logic is_pd;

  // ****************************************
  // serial receiver
  // ****************************************
  dds_frame_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .sclk(sclk),
    .sync_n(sync_n),
    .din(din),
    .enable(ctrl_en_reg),
    .evt(evt),
    .busy(rx_busy)
  );

  // word fields
  assign wd = evt.word;
  assign hit = evt.valid;
  assign is_load = hit && wd.mode == `DDS_MODE_LOAD;
  assign is_upd = hit && wd.mode == `DDS_MODE_UPD;
  assign is_all = hit && wd.mode == `DDS_MODE_ALL;
  assign is_pd = hit && wd.mode == `DDS_MODE_PD;

  // ****************************************
  // input holding codes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_a_reg <= '0;
    end else if (is_all) begin
      in_a_reg <= wd.code;
    end else if ((is_load || is_upd) && dds_sel_hit(wd.sel, `DDS_SEL_A)) begin
      in_a_reg <= wd.code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_b_reg <= '0;
    end else if (is_all) begin
      in_b_reg <= wd.code;
    end else if ((is_load || is_upd) && dds_sel_hit(wd.sel, `DDS_SEL_B)) begin
      in_b_reg <= wd.code;
    end
  end

  // ****************************************
  // output codes
  // ****************************************
  // an update word moves both outputs at once, the selected one from the
  // word and the other from its holding code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_a_reg <= '0;
    end else if (is_all) begin
      code_a_reg <= wd.code;
    end else if (is_upd) begin
      code_a_reg <= dds_sel_hit(wd.sel, `DDS_SEL_A) ? wd.code : in_a_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_b_reg <= '0;
    end else if (is_all) begin
      code_b_reg <= wd.code;
    end else if (is_upd) begin
      code_b_reg <= dds_sel_hit(wd.sel, `DDS_SEL_B) ? wd.code : in_b_reg;
    end
  end

  // ****************************************
  // power-down
  // ****************************************
  // select bits give the termination; an updating write wakes the outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_reg <= 1'h0;
      term_reg <= '0;
    end else if (is_pd) begin
      pd_reg <= 1'h1;
      term_reg <= wd.sel;
    end else if (is_upd || is_all) begin
      pd_reg <= 1'h0;
    end
  end

  // first updating write (update or all word) seen since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'h0;
    end else if (is_upd || is_all) begin
      seen_reg <= 1'h1;
    end
  end

  assign code_a = code_a_reg;
  assign code_b = code_b_reg;
  assign pd_active = pd_reg;
  assign pd_term = term_reg;

  // ****************************************
  // frame log and counters
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= '0;
    end else if (hit) begin
      last_reg <= wd;
    end
  end

  // an event in the clear cycle survives as a count of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_cnt_reg <= '0;
    end else if (hit) begin
      ok_cnt_reg <= cnt_clr ? `DDS_CNT_W'(1) : ok_cnt_reg + `DDS_CNT_W'(1);
    end else if (cnt_clr) begin
      ok_cnt_reg <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_cnt_reg <= '0;
    end else if (evt.abort) begin
      abort_cnt_reg <= cnt_clr ? `DDS_CNT_W'(1) : abort_cnt_reg + `DDS_CNT_W'(1);
    end else if (cnt_clr) begin
      abort_cnt_reg <= '0;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  function automatic logic addr_mapped(input logic [`DDS_AW-1:0] a);
    case (a)
      `DDS_ADDR_CTRL, `DDS_ADDR_STATUS, `DDS_ADDR_CODE_A,
      `DDS_ADDR_CODE_B, `DDS_ADDR_LAST, `DDS_ADDR_COUNT: return 1'h1;
      default: return 1'h0;
    endcase
  endfunction : addr_mapped

  // one wait state: pready rises in the second access cycle
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite && pready_reg;
  assign cnt_clr = apb_wr && paddr == `DDS_ADDR_CTRL && pwdata[`DDS_CTRL_CLR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
    end else begin
      pready_reg <= apb_access && !pready_reg;
      pslverr_reg <= apb_access && !pready_reg && !addr_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_reg <= `DDS_CTRL_EN_RST;
    end else if (apb_wr && paddr == `DDS_ADDR_CTRL) begin
      ctrl_en_reg <= pwdata[`DDS_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (apb_access && !pready_reg && !pwrite) begin
      case (paddr)
        `DDS_ADDR_CTRL: prdata_reg <= {31'h0, ctrl_en_reg};
        `DDS_ADDR_STATUS: prdata_reg <= {27'h0, seen_reg, rx_busy, pd_reg, term_reg};
        `DDS_ADDR_CODE_A: prdata_reg <= {22'h0, code_a_reg};
        `DDS_ADDR_CODE_B: prdata_reg <= {22'h0, code_b_reg};
        `DDS_ADDR_LAST: prdata_reg <= {16'h0, last_reg};
        `DDS_ADDR_COUNT: prdata_reg <= {abort_cnt_reg, ok_cnt_reg};
        default: prdata_reg <= '0;
      endcase
    end else if (!apb_access) begin
      prdata_reg <= '0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  upd_all_a: assert property (is_all |=>
    code_a_reg == $past(wd.code) && code_b_reg == $past(wd.code))
    else $error("simultaneous update missed");
  upd_sel_a: assert property (
    is_upd && wd.sel == `DDS_SEL_A |=>
    code_a_reg == $past(wd.code) && code_b_reg == $past(in_b_reg))
    else $error("individual update wrong");
  load_hold_a: assert property (is_load |=>
    $stable(code_a_reg) && $stable(code_b_reg))
    else $error("load-only word moved an output");
  abort_hold_a: assert property (evt.abort |=>
    $stable(code_a_reg) && $stable(code_b_reg) && $stable(pd_reg))
    else $error("aborted frame changed state");
  por_zero_a: assert property (!seen_reg |->
    code_a_reg == '0 && code_b_reg == '0)
    else $error("output nonzero before first write");
  pd_entry_a: assert property (is_pd |=>
    pd_reg && term_reg == $past(wd.sel))
    else $error("power-down not entered");
  apb_wait_a: assert property (apb_access && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not after one wait state");

  frame_c: cover property (hit);
  abort_c: cover property (evt.abort);
  pd_wake_c: cover property (is_pd ##[1:1000] (is_upd || is_all));
  apb_rd_c: cover property (apb_access && pready_reg && !pwrite);

endmodule : dds_top
`default_nettype wire

// ---- verif/dds_host_model.sv ----
// Purpose: serial host that writes frames into the converter block
// Assumes: serial clock idles high; between frames it moves only in idle_clocks
// Notes: falls beyond sixteen or short frames only when a test asks
`default_nettype none
module dds_host_model (
  // serial pins
  output logic sclk,
  output logic sync_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'h1;
    sync_n = 1'h1;
    din = 1'h0;
  end

  // ****************************************
  // frame with a chosen number of falls
  // ****************************************
  task automatic send(input logic [15:0] w, input int falls);
    sync_n = 1'h0;
    #137;
    for (int i = 0; i < falls; i++) begin
      din = (i < 16) ? w[15 - i] : ~din;
      #100;
      sclk = 1'h0;
      #100;
      sclk = 1'h1;
    end
    #100;
    sync_n = 1'h1;
    din = ~din;
    #200;
  endtask : send

  // ****************************************
  // clock edges with frame sync high
  // ****************************************
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      din = ~din;
      #100;
      sclk = 1'h0;
      #100;
      sclk = 1'h1;
    end
  endtask : idle_clocks
endmodule : dds_host_model
`default_nettype wire

// ---- verif/dual_dac_serial_input_tb.sv ----
// Purpose: self-checking bench of the converter serial-input block
// Assumes: host model drives the serial pins, bench drives apb
// Notes: outputs are checked after the host has closed each frame
`default_nettype none
`include "dds_consts.svh"
module dual_dac_serial_input_tb import dds_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [`DDS_AW-1:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sclk;
  logic sync_n;
  logic din;
  logic [`DDS_CODE_W-1:0] code_a;
  logic [`DDS_CODE_W-1:0] code_b;
  logic pd_active;
  logic [1:0] pd_term;
  logic [31:0] q;
  logic e;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  always #12.5 pclk = ~pclk;

  dds_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .sync_n(sync_n), .din(din), .code_a(code_a),
    .code_b(code_b), .pd_active(pd_active), .pd_term(pd_term));

  dds_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din));

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic outs(input logic [9:0] a, input logic [9:0] b, input logic p,
                      input logic [1:0] t);
    chk({9'h0, pd_active, pd_term, code_b, code_a}, {9'h0, p, t, b, a});
  endtask : outs

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'h0, a, 32'h0);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd

  task automatic frame(input logic [1:0] s, input logic [1:0] m, input logic [9:0] c,
                       input int falls);
    @(posedge pclk);
    host.send({s, m, c, 2'h3}, falls);
  endtask : frame

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    outs(10'h0, 10'h0, 1'h0, 2'h0);
    rd(8'h00, 32'h1, 1'h0);
    rd(8'h04, 32'h0, 1'h0);
    rd(8'h14, 32'h0, 1'h0);
    $display("test reset done");
    frame(2'h0, 2'h2, 10'h2A5, 16);
    outs(10'h2A5, 10'h2A5, 1'h0, 2'h0);
    rd(8'h10, 32'h0000_2A97, 1'h0);
    frame(2'h0, 2'h0, 10'h3FF, 16);
    outs(10'h2A5, 10'h2A5, 1'h0, 2'h0);
    frame(2'h1, 2'h1, 10'h155, 16);
    outs(10'h3FF, 10'h155, 1'h0, 2'h0);
    frame(2'h0, 2'h1, 10'h0AA, 16);
    outs(10'h0AA, 10'h155, 1'h0, 2'h0);
    frame(2'h1, 2'h0, 10'h123, 16);
    outs(10'h0AA, 10'h155, 1'h0, 2'h0);
    frame(2'h2, 2'h1, 10'h000, 16);
    outs(10'h0AA, 10'h123, 1'h0, 2'h0);
    frame(2'h0, 2'h2, 10'h0CC, 21);
    outs(10'h0CC, 10'h0CC, 1'h0, 2'h0);
    $display("test update modes done");
    frame(2'h0, 2'h2, 10'h111, 15);
    outs(10'h0CC, 10'h0CC, 1'h0, 2'h0);
    host.idle_clocks(16);
    repeat (12) @(posedge pclk);
    outs(10'h0CC, 10'h0CC, 1'h0, 2'h0);
    $display("test abort done");
    for (int t = 1; t < 4; t++) begin
      frame(t[1:0], 2'h3, 10'h200, 16);
      outs(10'h0CC, 10'h0CC, 1'h1, t[1:0]);
      rd(8'h04, {27'h0, 1'h1, 1'h0, 1'h1, t[1:0]}, 1'h0);
    end
    frame(2'h1, 2'h2, 10'h001, 16);
    chk({21'h0, pd_active, code_a}, {21'h0, 1'h0, 10'h001});
    rd(8'h14, 32'h0001_000B, 1'h0);
    $display("test power down done");
    apb(1'h1, 8'h00, 32'h0);
    frame(2'h0, 2'h2, 10'h3C3, 16);
    chk({12'h0, code_b, code_a}, {12'h0, 10'h001, 10'h001});
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h08, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h0);
    rd(8'h08, 32'h1, 1'h0);
    rd(8'h18, 32'h0, 1'h1);
    apb(1'h1, 8'h00, 32'h3);
    rd(8'h00, 32'h1, 1'h0);
    rd(8'h14, 32'h0, 1'h0);
    $display("test registers done");
    complete_run;
  end
endmodule : dual_dac_serial_input_tb
`default_nettype wire
